// >>> src/cwf_filter_cfg.sv
// Register part of a CAN selective-wake frame filter, reached over AHB-Lite.
// Assumes frame fields, restart and soft reset come from logic on hclk.
// Behaviour
// - A read/write byte holds expected identifier bits 12..5, bit 12 on top.
// - Identifier bits 4..0 sit in bits 6:2 of the low identifier byte.
// - Bit 1 of that byte is the expected remote flag, 0 for a data frame.
// - Bit 0 of that byte is the expected extension flag, 1 for 29 bits.
// - A set compare bit makes its identifier bit count, a clear one ignores it.
// - The compare bytes mirror the identifier layout, low bits in 6:2.
// - Reserved positions of the filter registers always read zero.
// - Length codes 0..7 mean that many bytes, 8..15 mean eight bytes.
// - The received length code must equal the stored one in every bit.
// - A read/write byte holds expected payload byte 7, bit 0 least.
// - Power-on and soft reset clear every filter register to zero.
// - A restart keeps the filter contents while reserved bits read zero.
// - Software sets the valid flag; wake, power-on or a filter write clear it.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

// ==========================================================================
// Top module
module cwf_filter_cfg (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Device reset requests
	input wire logic soft_reset,
	input wire logic restart,
	// Neighbouring filter bytes held elsewhere
	input wire logic [15:0] exp_id_upper,
	input wire logic [55:0] exp_payload_low,
	// Received frame
	input wire logic rx_frame_valid,
	input wire logic [28:0] rx_id,
	input wire logic rx_ide,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	// Results
	output logic wake_frame,
	output logic filter_config_valid
);

	cwf_pkg::cwf_bus_state_t state;
	cwf_pkg::cwf_bus_state_t next_state;
	logic [7:0] a_idx;
	logic a_write;
	logic [7:0] slot_q [0:cwf_pkg::NSLOT-1];

	wire logic addr_take;
	wire logic in_slot;
	wire logic hit_ctrl;
	wire logic [7:0] slot_off;
	wire logic [2:0] slot;
	wire logic commit;
	wire logic wr_slot;
	wire logic wr_ctrl;
	wire logic rd;
	wire logic [7:0] rd_value;
	wire logic [7:0] rd_mask;
	wire logic next_hreadyout;
	wire logic next_cfg;
	wire logic frame_hit;
	wire logic wake_hit;
	wire logic [28:0] exp_id;
	wire logic [28:0] id_compare;
	wire logic [63:0] exp_data;
	wire logic [63:0] filter_flat;

	// ======================================================================
	// Bus decode

	// Only the upper bit of htrans matters: NONSEQ and SEQ both start a transfer
	assign addr_take = hsel && htrans[1] && hready;

	// Captured index decode; upper address bits are not decoded and alias
	assign in_slot = (a_idx >= cwf_pkg::IDX_FIRST) && (a_idx <= cwf_pkg::IDX_LAST);
	assign hit_ctrl = a_idx == cwf_pkg::IDX_CTRL;
	assign slot_off = a_idx - cwf_pkg::IDX_FIRST;
	assign slot = slot_off[2:0];

	// Commit happens in the single wait cycle, when hwdata is already stable
	assign commit = state == cwf_pkg::CWF_ST_WAIT;
	assign wr_slot = commit && a_write && in_slot;
	assign wr_ctrl = commit && a_write && hit_ctrl;
	assign rd = commit && !a_write;

	// Unmapped reads return zero, unmapped writes are dropped
	assign rd_mask = in_slot ? cwf_pkg::SLOT_WMASK[{slot, 3'h0} +: 8] :
		(hit_ctrl ? cwf_pkg::CTRL_WMASK : 8'h00);
	assign rd_value = in_slot ? slot_q[slot] :
		(hit_ctrl ? {7'h00, filter_config_valid} : 8'h00);

	// ======================================================================
	// Transfer sequencing

	// Every transfer gets one wait state, so a read always sees prior writes
	always_comb begin
		next_state = state;
		unique case (state)
			cwf_pkg::CWF_ST_IDLE: begin
				if (addr_take) begin
					next_state = cwf_pkg::CWF_ST_WAIT;
				end
			end
			cwf_pkg::CWF_ST_WAIT: begin
				next_state = cwf_pkg::CWF_ST_DONE;
			end
			cwf_pkg::CWF_ST_DONE: begin
				next_state = addr_take ? cwf_pkg::CWF_ST_WAIT : cwf_pkg::CWF_ST_IDLE;
			end
		endcase
	end

	assign next_hreadyout = next_state != cwf_pkg::CWF_ST_WAIT;

	// Phase register and ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= cwf_pkg::CWF_ST_IDLE;
			hreadyout <= 1'b1;
		end else begin
			state <= next_state;
			hreadyout <= next_hreadyout;
		end
	end

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_idx <= 8'h00;
			a_write <= 1'b0;
		end else if (addr_take && state != cwf_pkg::CWF_ST_WAIT) begin
			a_idx <= haddr[9:2];
			a_write <= hwrite;
		end
	end

	// Read data stands from the wait cycle's end until the next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd) begin
			hrdata <= {24'h000000, rd_value & rd_mask};
		end
	end

	// The slave never signals an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ======================================================================
	// Filter registers

	// Only writable bits are stored, so reserved bits cannot read back set
	genvar g;
	generate
		for (g = 0; g < cwf_pkg::NSLOT; g++) begin : g_slot
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					slot_q[g] <= cwf_pkg::SLOT_RESET;
				end else if (soft_reset) begin
					slot_q[g] <= cwf_pkg::SLOT_RESET;
				end else if (wr_slot && slot == 3'(g)) begin
					slot_q[g] <= hwdata[7:0] & cwf_pkg::SLOT_WMASK[g*8 +: 8];
				end
			end
		end
	endgenerate

	// Restart leaves these flops alone; only the valid flag drops
	assign filter_flat = {slot_q[7], slot_q[6], slot_q[5], slot_q[4],
		slot_q[3], slot_q[2], slot_q[1], slot_q[0]};

	// ======================================================================
	// Expected frame assembly

	// Identifier bits 4..0 and the two frame-type flags share one byte
	assign exp_id = {exp_id_upper, slot_q[cwf_pkg::SL_ID_MID_LOW],
		slot_q[cwf_pkg::SL_ID_LOW_TYPE][cwf_pkg::ID_LOW_MSB:cwf_pkg::ID_LOW_LSB]};

	// Compare bytes follow the same layout as the identifier bytes
	assign id_compare = {slot_q[cwf_pkg::SL_MASK_TOP], slot_q[cwf_pkg::SL_MASK_MID_HIGH],
		slot_q[cwf_pkg::SL_MASK_MID_LOW],
		slot_q[cwf_pkg::SL_MASK_LOW][cwf_pkg::ID_LOW_MSB:cwf_pkg::ID_LOW_LSB]};

	// Payload byte 7 is the top byte of the expected data word
	assign exp_data = {slot_q[cwf_pkg::SL_PAYLOAD_SEVEN], exp_payload_low};

	// Standard identifiers are expected in bits 28..18 by the programmer
	cwf_match u_match (
		.exp_id(exp_id),
		.id_compare(id_compare),
		.exp_ide(slot_q[cwf_pkg::SL_ID_LOW_TYPE][cwf_pkg::IDE_BIT]),
		.exp_rtr(slot_q[cwf_pkg::SL_ID_LOW_TYPE][cwf_pkg::RTR_BIT]),
		.exp_dlc(slot_q[cwf_pkg::SL_LENGTH_CODE][cwf_pkg::DLC_MSB:0]),
		.exp_data(exp_data),
		.rx_id(rx_id),
		.rx_ide(rx_ide),
		.rx_rtr(rx_rtr),
		.rx_dlc(rx_dlc),
		.rx_data(rx_data),
		.hit(frame_hit)
	);

	// ======================================================================
	// Wake decision and valid flag

	// Nothing wakes until software has declared the filter valid
	assign wake_hit = rx_frame_valid && frame_hit && filter_config_valid;

	// Software setting the flag wins over a wake or write clearing it
	assign next_cfg = (soft_reset || restart) ? 1'b0 :
		wr_ctrl ? hwdata[cwf_pkg::CFG_VALID_BIT] :
		(wr_slot || wake_hit) ? 1'b0 : filter_config_valid;

	// Valid flag and one-cycle wake pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filter_config_valid <= 1'b0;
			wake_frame <= 1'b0;
		end else begin
			filter_config_valid <= next_cfg;
			wake_frame <= wake_hit;
		end
	end

	// ======================================================================
	// Assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_rsvd_zero;
		$past(rd) |-> (hrdata[31:8] == 24'h000000) && ((hrdata[7:0] & ~$past(rd_mask)) == 8'h00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

	property p_soft_clear;
		soft_reset |=> (filter_flat == 64'h0) && !filter_config_valid;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft reset left filter set");

	property p_restart_keep;
		restart && !soft_reset && !wr_slot |=> $stable(filter_flat) && !filter_config_valid;
	endproperty
	a_restart_keep: assert property (p_restart_keep) else $error("restart lost filter");

	property p_write_clears;
		wr_slot && !soft_reset |=> !filter_config_valid;
	endproperty
	a_write_clears: assert property (p_write_clears) else $error("valid kept after write");

	property p_wake_clears;
		wake_frame && !$past(wr_ctrl) |-> !filter_config_valid;
	endproperty
	a_wake_clears: assert property (p_wake_clears) else $error("valid kept after wake");

	property p_wake_cause;
		wake_frame |-> $past(rx_frame_valid) && $past(frame_hit) && $past(filter_config_valid);
	endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");

	// A software set in the same cycle keeps the flag up, so it is left out here
	property p_wake_follows;
		rx_frame_valid && frame_hit && filter_config_valid && !wr_ctrl
			|=> wake_frame ##1 !wake_frame;
	endproperty
	a_wake_follows: assert property (p_wake_follows) else $error("wake missing");

	property p_dlc_exact;
		rx_frame_valid && (rx_dlc != slot_q[cwf_pkg::SL_LENGTH_CODE][3:0]) |=> !wake_frame;
	endproperty
	a_dlc_exact: assert property (p_dlc_exact) else $error("wake on length mismatch");

	property p_type_match;
		rx_frame_valid && ({rx_rtr, rx_ide} != slot_q[cwf_pkg::SL_ID_LOW_TYPE][1:0]) |=> !wake_frame;
	endproperty
	a_type_match: assert property (p_type_match) else $error("wake on type mismatch");

	property p_write_store;
		wr_slot && !soft_reset && slot == cwf_pkg::SL_ID_MID_LOW
			|=> slot_q[cwf_pkg::SL_ID_MID_LOW] == $past(hwdata[7:0]);
	endproperty
	a_write_store: assert property (p_write_store) else $error("id byte not stored");

	property p_ready_wait;
		addr_take && state != cwf_pkg::CWF_ST_WAIT |=> !hreadyout ##1 hreadyout;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("wait state not exactly one");

	// Software decides the flag's value when it writes the control word, unless a soft reset or restart comes in the same cycle
	property p_cfg_set;
		wr_ctrl && !soft_reset && !restart |=> filter_config_valid == $past(hwdata[0]);
	endproperty
	a_cfg_set: assert property (p_cfg_set)
		else $error("valid flag not written");

	property p_no_wake_idle;
		rx_frame_valid && !filter_config_valid |=> !wake_frame;
	endproperty
	a_no_wake_idle: assert property (p_no_wake_idle)
		else $error("wake while filter not valid");

	property p_ctrl_read;
		rd && hit_ctrl |=> hrdata == {31'h0, $past(filter_config_valid)};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("valid flag read back wrong");

	// Each byte keeps exactly its writable bits, so reserved bits never leak into a compare
	property p_type_store;
		wr_slot && !soft_reset && slot == cwf_pkg::SL_ID_LOW_TYPE
			|=> slot_q[cwf_pkg::SL_ID_LOW_TYPE] == {1'b0, $past(hwdata[6:0])};
	endproperty
	a_type_store: assert property (p_type_store)
		else $error("type byte not stored");

	property p_mask_low_store;
		wr_slot && !soft_reset && slot == cwf_pkg::SL_MASK_LOW
			|=> slot_q[cwf_pkg::SL_MASK_LOW] == {1'b0, $past(hwdata[6:2]), 2'b00};
	endproperty
	a_mask_low_store: assert property (p_mask_low_store)
		else $error("low mask bits not stored");

	property p_len_store;
		wr_slot && !soft_reset && slot == cwf_pkg::SL_LENGTH_CODE
			|=> slot_q[cwf_pkg::SL_LENGTH_CODE] == {4'h0, $past(hwdata[3:0])};
	endproperty
	a_len_store: assert property (p_len_store)
		else $error("length code not stored");

	property p_payload_store;
		wr_slot && !soft_reset && slot == cwf_pkg::SL_PAYLOAD_SEVEN
			|=> slot_q[cwf_pkg::SL_PAYLOAD_SEVEN] == $past(hwdata[7:0]);
	endproperty
	a_payload_store: assert property (p_payload_store)
		else $error("payload byte not stored");

endmodule

// >>> src/cwf_pkg.sv
// Constants and types for the CAN wake-frame filter configuration block.
// Assumes a 32-bit AHB-Lite register bus and one 10 MHz clock domain.

// ==========================================================================
// Package
package cwf_pkg;

	// Clock period of hclk in nanoseconds
	localparam int CLK_PERIOD_NS = 100;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h20;
	localparam logic [7:0] IDX_ID_MID_LOW = 8'h25;
	localparam logic [7:0] IDX_ID_LOW_TYPE = 8'h26;
	localparam logic [7:0] IDX_MASK_TOP = 8'h27;
	localparam logic [7:0] IDX_MASK_MID_HIGH = 8'h28;
	localparam logic [7:0] IDX_MASK_MID_LOW = 8'h29;
	localparam logic [7:0] IDX_MASK_LOW = 8'h2a;
	localparam logic [7:0] IDX_LENGTH_CODE = 8'h2b;
	localparam logic [7:0] IDX_PAYLOAD_SEVEN = 8'h2c;

	// Filter registers form one contiguous run of slots
	localparam int NSLOT = 8;
	localparam logic [7:0] IDX_FIRST = IDX_ID_MID_LOW;
	localparam logic [7:0] IDX_LAST = IDX_PAYLOAD_SEVEN;
	localparam logic [2:0] SL_ID_MID_LOW = 3'h0;
	localparam logic [2:0] SL_ID_LOW_TYPE = 3'h1;
	localparam logic [2:0] SL_MASK_TOP = 3'h2;
	localparam logic [2:0] SL_MASK_MID_HIGH = 3'h3;
	localparam logic [2:0] SL_MASK_MID_LOW = 3'h4;
	localparam logic [2:0] SL_MASK_LOW = 3'h5;
	localparam logic [2:0] SL_LENGTH_CODE = 3'h6;
	localparam logic [2:0] SL_PAYLOAD_SEVEN = 3'h7;

	// Writable bits per slot, slot 7 in the top byte; the rest read zero
	localparam logic [63:0] SLOT_WMASK = 64'hff0f7cffffff7fff;
	localparam logic [7:0] CTRL_WMASK = 8'h01;
	localparam logic [7:0] SLOT_RESET = 8'h00;

	// Field positions
	localparam int IDE_BIT = 0;
	localparam int RTR_BIT = 1;
	localparam int ID_LOW_LSB = 2;
	localparam int ID_LOW_MSB = 6;
	localparam int CFG_VALID_BIT = 0;
	localparam int DLC_MSB = 3;
	localparam logic [3:0] PAYLOAD_MAX = 4'h8;

	// Bus transfer phases
	typedef enum logic [1:0] {
		CWF_ST_IDLE,
		CWF_ST_WAIT,
		CWF_ST_DONE
	} cwf_bus_state_t;

endpackage

// >>> src/cwf_match.sv
// Combinational compare of one received frame against the expected frame.
// Assumes all inputs are stable in the cycle that the caller samples.
`timescale 1ns/1ps

// ==========================================================================
// Frame comparator
module cwf_match (
	// Expected frame
	input wire logic [28:0] exp_id,
	input wire logic [28:0] id_compare,
	input wire logic exp_ide,
	input wire logic exp_rtr,
	input wire logic [3:0] exp_dlc,
	input wire logic [63:0] exp_data,
	// Received frame
	input wire logic [28:0] rx_id,
	input wire logic rx_ide,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	// Result
	output wire logic hit
);

	wire logic [3:0] nbytes;
	wire logic [7:0] byte_ok;
	wire logic id_ok;

	// Codes 8 to 15 all carry eight payload bytes
	assign nbytes = rx_dlc[3] ? cwf_pkg::PAYLOAD_MAX : {1'b0, rx_dlc[2:0]};

	// A clear compare bit leaves that identifier bit free
	assign id_ok = ((exp_id ^ rx_id) & id_compare) == 29'h0;

	// Bytes beyond the frame's length never take part
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_byte
			assign byte_ok[g] = (4'(g) >= nbytes) ||
				(exp_data[g*8 +: 8] == rx_data[g*8 +: 8]);
		end
	endgenerate

	// Length code must agree bit by bit, not only in byte count
	assign hit = id_ok && (exp_ide == rx_ide) && (exp_rtr == rx_rtr) &&
		(exp_dlc == rx_dlc) && (byte_ok == 8'hff);

endmodule

// >>> sim/cwf_frame_src.sv
// Model of a CAN node that hands received wake frames to the filter.
// Assumes send_frame is called from a bench process running on hclk.
`timescale 1ns/1ps

// ==========================================================================
// Frame source
module cwf_frame_src (
	// Clock
	input wire logic hclk,
	// Received frame
	output logic rx_frame_valid,
	output logic [28:0] rx_id,
	output logic rx_ide,
	output logic rx_rtr,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data
);
	// Quiet receiver until the first frame arrives
	initial begin
		rx_frame_valid = 1'b0;
		{rx_id, rx_ide, rx_rtr, rx_dlc, rx_data} = '0;
	end

	// One frame for one cycle, then the inverse so stale fields never match
	task automatic send_frame(input logic [28:0] id, input logic ide, input logic rtr,
		input logic [3:0] dlc, input logic [63:0] d);
		@(posedge hclk);
		rx_frame_valid <= 1'b1;
		{rx_id, rx_ide, rx_rtr, rx_dlc, rx_data} <= {id, ide, rtr, dlc, d};
		@(posedge hclk);
		rx_frame_valid <= 1'b0;
		{rx_id, rx_ide, rx_rtr, rx_dlc, rx_data} <= ~{id, ide, rtr, dlc, d};
	endtask
endmodule

// >>> sim/tb_cwf_filter_cfg.sv
// Self-checking bench for the wake-frame filter configuration block.
// Assumes the block is the only AHB-Lite slave, so hready is its hreadyout.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module tb_cwf_filter_cfg;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = '0;
	logic soft_reset = 1'b0;
	logic restart = 1'b0;
	logic [15:0] exp_id_upper = '0;
	logic [55:0] exp_payload_low = '0;
	logic [31:0] hrdata, rd;
	logic hready, hreadyout, hresp, wake_frame, filter_config_valid;
	logic rx_frame_valid, rx_ide, rx_rtr;
	logic [28:0] rx_id;
	logic [3:0] rx_dlc;
	logic [63:0] rx_data;
	int err_count = 0;
	int compares = 0;
	// Writable bits of the eight filter registers in index order
	logic [7:0] wmask [8] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7c, 8'h0f, 8'hff};
	localparam logic [28:0] XID = 29'h1357_9bdf;
	localparam logic [28:0] SID = {11'h5a3, 18'h0};
	localparam logic [63:0] DAT = 64'h0123_4567_89ab_cdef;

	// Clock and single-slave ready loop
	always #(cwf_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;
	assign hready = hreadyout;

	cwf_filter_cfg u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .soft_reset(soft_reset),
		.restart(restart), .exp_id_upper(exp_id_upper), .exp_payload_low(exp_payload_low),
		.rx_frame_valid(rx_frame_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr),
		.rx_dlc(rx_dlc), .rx_data(rx_data), .wake_frame(wake_frame),
		.filter_config_valid(filter_config_valid));

	cwf_frame_src u_src (.hclk(hclk), .rx_frame_valid(rx_frame_valid), .rx_id(rx_id),
		.rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data));

	// ==========================================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Waits as long as the slave needs; a stuck slave is caught by the watchdog
	task automatic wait_ready();
		do begin
			@(posedge hclk);
		end while (hready !== 1'b1);
	endtask

	// One single word transfer; read data taken at the completing edge
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_ready();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		bus(1'b1, idx, v);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(rd, {24'h0, e});
	endtask

	// Load the expected frame; the remote flag is always left at 0
	task automatic cfg(input logic [28:0] id, input logic [28:0] m, input logic ide,
		input logic [3:0] dlc, input logic [63:0] d);
		exp_id_upper <= id[28:13];
		exp_payload_low <= d[55:0];
		wr(cwf_pkg::IDX_ID_MID_LOW, id[12:5]);
		wr(cwf_pkg::IDX_ID_LOW_TYPE, {1'b0, id[4:0], 1'b0, ide});
		wr(cwf_pkg::IDX_MASK_TOP, m[28:21]);
		wr(cwf_pkg::IDX_MASK_MID_HIGH, m[20:13]);
		wr(cwf_pkg::IDX_MASK_MID_LOW, m[12:5]);
		wr(cwf_pkg::IDX_MASK_LOW, {1'b0, m[4:0], 2'b00});
		wr(cwf_pkg::IDX_LENGTH_CODE, {4'h0, dlc});
		wr(cwf_pkg::IDX_PAYLOAD_SEVEN, d[63:56]);
	endtask

	// Arm the flag, send one frame, expect a wake pulse or none
	task automatic fr(input logic [28:0] id, input logic ide, input logic rtr,
		input logic [3:0] dlc, input logic [63:0] d, input logic hit);
		wr(cwf_pkg::IDX_CTRL, 8'h01);
		u_src.send_frame(id, ide, rtr, dlc, d);
		#1;
		chk({31'h0, wake_frame}, {31'h0, hit});
		chk({31'h0, filter_config_valid}, {31'h0, ~hit});
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset();
		rdchk(cwf_pkg::IDX_CTRL, 8'h00);
		for (int i = 0; i < 8; i++) rdchk(cwf_pkg::IDX_FIRST + 8'(i), 8'h00);
	endtask

	// Writable bits stick, reserved bits read zero, unmapped index ignored
	task automatic t_access();
		for (int i = 0; i < 8; i++) begin
			wr(cwf_pkg::IDX_FIRST + 8'(i), 8'hff);
			rdchk(cwf_pkg::IDX_FIRST + 8'(i), wmask[i]);
			wr(cwf_pkg::IDX_FIRST + 8'(i), 8'h00);
			rdchk(cwf_pkg::IDX_FIRST + 8'(i), 8'h00);
		end
		wr(8'h30, 8'hff);
		rdchk(8'h30, 8'h00);
	endtask

	// Valid flag against filter writes, restart and soft reset
	task automatic t_flag();
		wr(cwf_pkg::IDX_CTRL, 8'h01);
		#1;
		chk({31'h0, filter_config_valid}, 32'h1);
		rdchk(cwf_pkg::IDX_CTRL, 8'h01);
		wr(cwf_pkg::IDX_PAYLOAD_SEVEN, 8'h3c);
		wr(cwf_pkg::IDX_LENGTH_CODE, 8'hfa);
		#1;
		chk({31'h0, filter_config_valid}, 32'h0);
		wr(cwf_pkg::IDX_CTRL, 8'h01);
		@(posedge hclk);
		restart <= 1'b1;
		@(posedge hclk);
		restart <= 1'b0;
		#1;
		chk({31'h0, filter_config_valid}, 32'h0);
		rdchk(cwf_pkg::IDX_PAYLOAD_SEVEN, 8'h3c);
		rdchk(cwf_pkg::IDX_LENGTH_CODE, 8'h0a);
		wr(cwf_pkg::IDX_CTRL, 8'h01);
		@(posedge hclk);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		#1;
		chk({31'h0, filter_config_valid}, 32'h0);
		rdchk(cwf_pkg::IDX_PAYLOAD_SEVEN, 8'h00);
		rdchk(cwf_pkg::IDX_LENGTH_CODE, 8'h00);
	endtask

	// Extended frame: exact match wakes once, any differing field does not
	task automatic t_match();
		cfg(XID, '1, 1'b1, 4'h8, DAT);
		fr(XID, 1'b1, 1'b0, 4'h8, DAT, 1'b1);
		u_src.send_frame(XID, 1'b1, 1'b0, 4'h8, DAT);
		#1;
		chk({31'h0, wake_frame}, 32'h0);
		fr(XID ^ 29'h1, 1'b1, 1'b0, 4'h8, DAT, 1'b0);
		fr(XID ^ 29'h1000, 1'b1, 1'b0, 4'h8, DAT, 1'b0);
		fr(XID, 1'b0, 1'b0, 4'h8, DAT, 1'b0);
		fr(XID, 1'b1, 1'b1, 4'h8, DAT, 1'b0);
		fr(XID, 1'b1, 1'b0, 4'h9, DAT, 1'b0);
		fr(XID, 1'b1, 1'b0, 4'h8, DAT ^ {8'h01, 56'h0}, 1'b0);
	endtask

	// Standard identifier, ignored bits and short or long lengths
	task automatic t_mask();
		cfg(SID, ~29'h8, 1'b0, 4'h2, DAT);
		fr(SID ^ 29'h8, 1'b0, 1'b0, 4'h2, DAT, 1'b1);
		fr(SID ^ 29'h10, 1'b0, 1'b0, 4'h2, DAT, 1'b0);
		fr(SID, 1'b0, 1'b0, 4'h2, DAT ^ 64'h1_0000, 1'b1);
		fr(SID, 1'b0, 1'b0, 4'h2, DAT ^ 64'h100, 1'b0);
		cfg(SID, '1, 1'b0, 4'hf, DAT);
		fr(SID, 1'b0, 1'b0, 4'hf, DAT ^ {8'h01, 56'h0}, 1'b0);
		fr(SID, 1'b0, 1'b0, 4'hf, DAT, 1'b1);
	endtask

	// ==========================================================================
	// Verdict
	task automatic complete_run();
		if (err_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_access();
		t_flag();
		t_match();
		t_mask();
		complete_run();
	end

	// Watchdog, far beyond the ninety bus transfers of the run
	initial begin
		#5000000;
		err_count++;
		complete_run();
	end
endmodule
